// [common/cct_pkg.sv]
// Shared constants and types for the capture/compare timer
package cct_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] OFS_STAT   = 8'h40;
  localparam logic [7:0] OFS_CNT_HI = 8'h41;
  localparam logic [7:0] OFS_CNT_LO = 8'h42;
  localparam logic [7:0] OFS_LIM_HI = 8'h43;
  localparam logic [7:0] OFS_LIM_LO = 8'h44;
  // Index 0 is channel 0, index 1 is channel 1
  localparam logic [1:0][7:0] OFS_CH_CTRL = {8'h48, 8'h45};
  localparam logic [1:0][7:0] OFS_CH_HI   = {8'h49, 8'h46};
  localparam logic [1:0][7:0] OFS_CH_LO   = {8'h4a, 8'h47};

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int B_FLAG = 7;  // Event flag in status and channel regs
  localparam int B_IE   = 6;  // Interrupt enable
  localparam int B_STOP = 5;  // Counter stop (status)
  localparam int B_CLR  = 4;  // Counter and prescaler clear (status)
  localparam int B_LINK = 5;  // Channel link (channel 0 only)
  localparam int B_MSA  = 4;  // Compare mode select
  localparam int B_ELS  = 2;  // Edge/level select, two bits
  localparam int B_TOV  = 1;  // Toggle on wrap
  localparam int B_MAX  = 0;  // Full duty force

  // ****************************************************
  // Widths and reset values
  // ****************************************************
  localparam int         CNT_W     = 16;
  localparam int         DIV_W     = 6;
  localparam logic [2:0] PS_EXT    = 3'h7;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  localparam logic [2:0] PS_RST    = 3'h0;
  localparam logic       STOP_RST  = 1'h0;

  typedef enum logic [1:0] {
    CM_IDLE    = 2'b00,
    CM_CAPTURE = 2'b01,
    CM_COMPARE = 2'b10,
    CM_LINKED  = 2'b11
  } cct_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cct_bus_req_t;

endpackage : cct_pkg

// [verilog/cct_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module cct_sync #(
  parameter int W = 3
) (
  input  wire logic         ref_clk_in, // Bus clock
  input  wire logic         rst_n_in,   // Sync reset, low
  input  wire logic         ce_in,      // Clock enable
  input  wire logic [W-1:0] async_in,   // Raw pin levels
  output logic      [W-1:0] rise_out,   // Rising edge pulse
  output logic      [W-1:0] fall_out    // Falling edge pulse
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else if (ce_in) begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // A change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
                                                  : lvl_reg[i];
    assign rise_out[i] = ce_in & lvl_next[i] & ~lvl_reg[i];
    assign fall_out[i] = ce_in & ~lvl_next[i] & lvl_reg[i];
  end

endmodule : cct_sync

// [verilog/cct_prescaler.sv]
// Counter clock prescaler: seven bus clock rates or the external pin
`timescale 1ns/1ps
module cct_prescaler (
  input  wire logic       ref_clk_in,  // Bus clock
  input  wire logic       rst_n_in,    // Sync reset, low
  input  wire logic       ce_in,       // Clock enable
  input  wire logic       clear_in,    // Restart the divider
  input  wire logic       run_in,      // Counter not stopped
  input  wire logic [2:0] ps_in,       // Rate select
  input  wire logic       ext_rise_in, // Synchronised pin edge
  output logic            tick_out     // One count step
);
  import cct_pkg::*;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else if (ce_in) begin
      if (clear_in) begin
        div_reg <= '0;
      end else if (run_in) begin
        div_reg <= DIV_W'(div_reg + 1'b1);
      end
    end
  end

  // Divide by 2**ps; ps of zero gives a step every bus cycle
  assign mask = DIV_W'((7'h01 << ps_in) - 7'h01); // R4

  always_comb begin
    if (!ce_in || !run_in || clear_in) begin
      tick_out = 1'b0;
    end else if (ps_in == PS_EXT) begin
      tick_out = ext_rise_in; // R4
    end else begin
      tick_out = ((div_reg & mask) == mask);
    end
  end

  a_direct_rate: assert property (@(posedge ref_clk_in) // R20
    disable iff (!rst_n_in)
    ce_in && run_in && !clear_in && ps_in == 3'h0 |-> tick_out)
    else $error("Rate zero did not step every cycle");

endmodule : cct_prescaler

// [verilog/cct_timer.sv]
// Two-channel capture/compare timer with byte register port
`timescale 1ns/1ps
// Behaviour
// R1 - 16-bit up-counter, free or modulo
// R2 - Counter reads never disturb counting
// R3 - Two channels, each capture or compare
// R4 - Seven bus rates or external pin clock
// R5 - Selected pin edge captures counter value
// R6 - Every capture overwrites, flag set or not
// R7 - Captured value stored shortly after edge
// R8 - Set channel flag requests interrupt if enabled
// R9 - Reset leaves channel values unchanged
// R10 - Compare match sets, clears or toggles pin
// R11 - Compare match sets flag, may interrupt
// R12 - Compare only against currently held value
// R13 - Software times unbuffered value updates
// R14 - Link bit joins channels, output on pin0
// R15 - Last written pair takes over at wrap
// R16 - Linked: channel 1 unused, pin released
// R17 - Software writes only the inactive pair
// R18 - Toggle on wrap makes PWM period
// R19 - Software picks compare action for polarity
// R20 - Limit 255, rate zero: 256 cycles
// R21 - Wrap flag set at limit, interrupt enable
// R22 - Link bit overrides compare mode bit
// R23 - No wrap toggle gives zero duty
// R24 - Full duty force with toggle: 100%
// R25 - Counter returns to zero after limit
// R26 - Pins synchronised before edge detection
module cct_timer (
  input  wire logic          ref_clk_in,        // Bus clock, 100 MHz
  input  wire logic          rst_n_in,          // Sync reset, low
  input  wire logic          ce_in,             // Freezes all state
  input  cct_pkg::cct_bus_req_t bus_in,         // Register request
  output logic [7:0]         rdata_out,         // Read data, next cycle
  input  wire logic          ext_clk_pin_in,    // External count clock
  input  wire logic [1:0]    chan_pin_in,       // Channel pin levels
  output logic [1:0]         chan_pin_out,      // Channel pin drive
  output logic [1:0]         chan_pin_oe_n_out, // Low while driving
  output logic               wrap_irq_out,      // Wrap request
  output logic [1:0]         chan_irq_out       // Channel requests
);
  import cct_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] limit_reg;
  logic             wrap_flag_reg;
  logic             wrap_ie_reg;
  logic             stop_reg;
  logic [2:0]       ps_reg;
  logic             link_reg;
  logic             act1_reg;
  logic             pend1_reg;
  logic             wrap_irq_reg;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic             tick;
  logic             reach;
  logic             clr;
  logic             st_wr;
  logic [2:0]       pin_rise;
  logic [2:0]       pin_fall;

  logic             flag_reg  [2];
  logic             ie_reg    [2];
  logic             msa_reg   [2];
  logic [1:0]       els_reg   [2];
  logic             tov_reg   [2];
  logic             max_reg   [2];
  logic [CNT_W-1:0] val_reg   [2];
  logic [CNT_W-1:0] cmp_val   [2];
  logic             pin_reg   [2];
  logic             pin_next  [2];
  logic             oe_n_reg  [2];
  logic             irq_reg   [2];
  cct_mode_t        mode      [2];
  logic             capt      [2];
  logic             match     [2];
  logic             ctrl_wr   [2];
  logic             hi_wr     [2];
  logic             lo_wr     [2];

  // ****************************************************
  // Pin synchronisers and prescaler
  // ****************************************************
  cct_sync #(.W (3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   ({ext_clk_pin_in, chan_pin_in}), // R26
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  cct_prescaler u_presc (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .clear_in    (clr),
    .run_in      (~stop_reg),
    .ps_in       (ps_reg),
    .ext_rise_in (pin_rise[2]),
    .tick_out    (tick)
  );

  // ****************************************************
  // Counter and status register
  // ****************************************************
  assign st_wr = bus_in.wr && bus_in.addr == OFS_STAT;
  assign clr   = st_wr && bus_in.wdata[B_CLR];

  // A limit below the count lets it run on through all ones
  assign cnt_next = (cnt_reg == limit_reg) ? '0 // R25
                                           : CNT_W'(cnt_reg + 1'b1);
  assign reach = tick && cnt_next == limit_reg; // R21

  always_ff @(posedge ref_clk_in) begin // R1
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else if (ce_in) begin
      if (clr) begin
        cnt_reg <= '0;
      end else if (tick) begin
        cnt_reg <= cnt_next;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      limit_reg <= LIMIT_RST;
    end else if (ce_in && bus_in.wr) begin
      if (bus_in.addr == OFS_LIM_HI) begin
        limit_reg[15:8] <= bus_in.wdata;
      end
      if (bus_in.addr == OFS_LIM_LO) begin
        limit_reg[7:0] <= bus_in.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wrap_flag_reg <= 1'b0;
      wrap_ie_reg   <= 1'b0;
      stop_reg      <= STOP_RST;
      ps_reg        <= PS_RST;
      wrap_irq_reg  <= 1'b0;
    end else if (ce_in) begin
      if (st_wr) begin
        wrap_ie_reg <= bus_in.wdata[B_IE];
        stop_reg    <= bus_in.wdata[B_STOP];
        ps_reg      <= bus_in.wdata[2:0];
      end
      // A wrap in the clearing cycle is kept
      if (reach) begin
        wrap_flag_reg <= 1'b1; // R21
      end else if (st_wr && !bus_in.wdata[B_FLAG]) begin
        wrap_flag_reg <= 1'b0;
      end
      wrap_irq_reg <= wrap_flag_reg & wrap_ie_reg; // R21
    end
  end

  // ****************************************************
  // Linked pair selection
  // ****************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      link_reg  <= 1'b0;
      act1_reg  <= 1'b0;
      pend1_reg <= 1'b0;
    end else if (ce_in) begin
      if (ctrl_wr[0]) begin
        link_reg <= bus_in.wdata[B_LINK]; // R14
      end
      if (!link_reg) begin
        act1_reg  <= 1'b0; // R15
        pend1_reg <= 1'b0;
      end else begin
        if (hi_wr[1] || lo_wr[1]) begin
          pend1_reg <= 1'b1; // R15
        end else if (hi_wr[0] || lo_wr[0]) begin
          pend1_reg <= 1'b0;
        end
        if (reach) begin
          act1_reg <= pend1_reg; // R15
        end
      end
    end
  end

  // ****************************************************
  // Channels
  // ****************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch // R3
    assign ctrl_wr[i] = bus_in.wr && bus_in.addr == OFS_CH_CTRL[i];
    assign hi_wr[i]   = bus_in.wr && bus_in.addr == OFS_CH_HI[i];
    assign lo_wr[i]   = bus_in.wr && bus_in.addr == OFS_CH_LO[i];

    always_comb begin
      if (link_reg) begin
        mode[i] = (i == 0) ? CM_LINKED : CM_IDLE; // R22 R16
      end else if (msa_reg[i]) begin
        mode[i] = CM_COMPARE;
      end else if (els_reg[i] != 2'b00) begin
        mode[i] = CM_CAPTURE;
      end else begin
        mode[i] = CM_IDLE;
      end
    end

    // Only the held value is compared, so a value already passed
    // waits for the next period
    assign cmp_val[i] = (i == 0 && link_reg && act1_reg) ? val_reg[1]
                                                          : val_reg[i];
    assign match[i] = tick && cnt_next == cmp_val[i] // R10 R12
                      && (mode[i] == CM_COMPARE || mode[i] == CM_LINKED);
    assign capt[i]  = mode[i] == CM_CAPTURE // R5
                      && ((els_reg[i][0] && pin_rise[i])
                      ||  (els_reg[i][1] && pin_fall[i]));

    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
        flag_reg[i] <= 1'b0;
        ie_reg[i]   <= 1'b0;
        msa_reg[i]  <= 1'b0;
        els_reg[i]  <= 2'b00;
        tov_reg[i]  <= 1'b0;
        max_reg[i]  <= 1'b0;
        irq_reg[i]  <= 1'b0;
      end else if (ce_in) begin
        if (ctrl_wr[i]) begin
          ie_reg[i]  <= bus_in.wdata[B_IE];
          msa_reg[i] <= bus_in.wdata[B_MSA];
          els_reg[i] <= bus_in.wdata[B_ELS+1:B_ELS];
          tov_reg[i] <= bus_in.wdata[B_TOV];
          max_reg[i] <= bus_in.wdata[B_MAX];
        end
        if (capt[i] || match[i]) begin
          flag_reg[i] <= 1'b1; // R11
        end else if (ctrl_wr[i] && !bus_in.wdata[B_FLAG]) begin
          flag_reg[i] <= 1'b0;
        end
        irq_reg[i] <= flag_reg[i] & ie_reg[i]; // R8
      end
    end

    // No reset here: captured and compare values survive reset
    always_ff @(posedge ref_clk_in) begin // R9
      if (ce_in) begin
        if (capt[i]) begin
          val_reg[i] <= cnt_reg; // R6 R7
        end else begin
          if (hi_wr[i]) begin
            val_reg[i][15:8] <= bus_in.wdata;
          end
          if (lo_wr[i]) begin
            val_reg[i][7:0] <= bus_in.wdata;
          end
        end
      end
    end

    // Wrap toggle first, then the compare action on top of it
    always_comb begin
      pin_next[i] = pin_reg[i];
      if (mode[i] == CM_COMPARE || mode[i] == CM_LINKED) begin
        if (reach && tov_reg[i]) begin
          pin_next[i] = max_reg[i] | ~pin_reg[i]; // R18 R23 R24
        end
        if (match[i] && !(max_reg[i] && tov_reg[i])) begin
          case (els_reg[i])
            2'b01:   pin_next[i] = ~pin_next[i]; // R10
            2'b10:   pin_next[i] = 1'b0;
            2'b11:   pin_next[i] = 1'b1;
            default: pin_next[i] = pin_next[i];
          endcase
        end
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
        pin_reg[i]  <= 1'b0;
        oe_n_reg[i] <= 1'b1;
      end else if (ce_in) begin
        pin_reg[i]  <= pin_next[i];
        oe_n_reg[i] <= !((mode[i] == CM_COMPARE // R16
                       || mode[i] == CM_LINKED)
                       && els_reg[i] != 2'b00);
      end
    end

    assign chan_pin_out[i]      = pin_reg[i];
    assign chan_pin_oe_n_out[i] = oe_n_reg[i];
    assign chan_irq_out[i]      = irq_reg[i];
  end

  // ****************************************************
  // Register read port
  // ****************************************************
  always_comb begin
    rdata_next = 8'h00;
    case (bus_in.addr)
      OFS_STAT:
        rdata_next = {wrap_flag_reg, wrap_ie_reg, stop_reg, 2'b00,
                      ps_reg};
      OFS_CNT_HI: rdata_next = cnt_reg[15:8]; // R2
      OFS_CNT_LO: rdata_next = cnt_reg[7:0];
      OFS_LIM_HI: rdata_next = limit_reg[15:8];
      OFS_LIM_LO: rdata_next = limit_reg[7:0];
      OFS_CH_CTRL[0]:
        rdata_next = {flag_reg[0], ie_reg[0], link_reg, msa_reg[0],
                      els_reg[0], tov_reg[0], max_reg[0]};
      OFS_CH_CTRL[1]:
        rdata_next = {flag_reg[1], ie_reg[1], 1'b0, msa_reg[1],
                      els_reg[1], tov_reg[1], max_reg[1]};
      OFS_CH_HI[0]: rdata_next = val_reg[0][15:8];
      OFS_CH_LO[0]: rdata_next = val_reg[0][7:0];
      OFS_CH_HI[1]: rdata_next = val_reg[1][15:8];
      OFS_CH_LO[1]: rdata_next = val_reg[1][7:0];
      default:    rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else if (ce_in) begin
      rdata_reg <= bus_in.rd ? rdata_next : 8'h00;
    end
  end

  assign rdata_out    = rdata_reg;
  assign wrap_irq_out = wrap_irq_reg;

  // ****************************************************
  // Checks
  // ****************************************************
  a_wrap_to_zero: assert property (@(posedge ref_clk_in) // R25
    disable iff (!rst_n_in)
    ce_in && tick && !clr && cnt_reg == limit_reg |=> cnt_reg == '0)
    else $error("Counter did not return to zero after limit");
  a_read_no_effect: assert property (@(posedge ref_clk_in) // R2
    disable iff (!rst_n_in)
    ce_in && bus_in.rd && !tick && !clr |=> $stable(cnt_reg))
    else $error("Counter read moved the count");
  a_capture_value: assert property (@(posedge ref_clk_in) // R5
    disable iff (!rst_n_in)
    ce_in && capt[1] |=> val_reg[1] == $past(cnt_reg)
                         && flag_reg[1])
    else $error("Capture did not store the count");
  a_flag_irq: assert property (@(posedge ref_clk_in) // R8
    disable iff (!rst_n_in)
    ce_in && ie_reg[1] && (capt[1] || match[1])
    ##1 ce_in [*2] |-> chan_irq_out[1])
    else $error("Channel flag gave no request");
  a_wrap_flag: assert property (@(posedge ref_clk_in) // R21
    disable iff (!rst_n_in)
    ce_in && reach |=> wrap_flag_reg)
    else $error("Wrap flag not set at limit");
  a_wrap_toggle: assert property (@(posedge ref_clk_in) // R18
    disable iff (!rst_n_in)
    ce_in && reach && tov_reg[0] && !max_reg[0] && !match[0]
    && mode[0] == CM_COMPARE |=> pin_reg[0] != $past(pin_reg[0]))
    else $error("Pin did not toggle at wrap");
  a_full_duty: assert property (@(posedge ref_clk_in) // R24
    disable iff (!rst_n_in)
    ce_in && reach && tov_reg[0] && max_reg[0]
    && mode[0] != CM_IDLE && mode[0] != CM_CAPTURE |=> pin_reg[0])
    else $error("Full duty did not hold pin high");
  a_link_release: assert property (@(posedge ref_clk_in) // R16
    disable iff (!rst_n_in)
    ce_in && link_reg |=> chan_pin_oe_n_out[1] && mode[1] == CM_IDLE)
    else $error("Channel 1 pin not released while linked");
  a_pair_swap: assert property (@(posedge ref_clk_in) // R15
    disable iff (!rst_n_in)
    ce_in && link_reg && reach |=> act1_reg == $past(pend1_reg))
    else $error("Linked pair did not swap at wrap");
  a_compare_set: assert property (@(posedge ref_clk_in) // R10
    disable iff (!rst_n_in)
    ce_in && match[0] && els_reg[0] == 2'b11 && !tov_reg[0]
    |=> pin_reg[0])
    else $error("Compare set action missing");

endmodule : cct_timer

// [dv/cct_pin_model.sv]
// Far-side model of the channel pins and the external count clock pin
`timescale 1ns/1ps
module cct_pin_model (
  input  wire logic       ref_clk_in, // Bench clock, pacing only
  input  wire logic [1:0] drv_in,     // Timer pin drive
  input  wire logic [1:0] oe_n_in,    // Timer drive enable, low
  output logic      [1:0] pin_out,    // Resolved pin level
  output logic            ext_clk_out // External count clock
);
  logic [1:0] lvl_reg = 2'h0;

  // ****************************************************
  // Pin resolution and stimulus
  // ****************************************************
  // Timer wins while it drives; otherwise the outside level shows
  assign pin_out[0] = oe_n_in[0] ? lvl_reg[0] : drv_in[0];
  assign pin_out[1] = oe_n_in[1] ? lvl_reg[1] : drv_in[1];
  initial ext_clk_out = 1'b0;

  task automatic set_pin(input int i, input logic v);
    @(posedge ref_clk_in);
    lvl_reg[i] <= v;
  endtask : set_pin

  // Clock stands still between bursts; slow enough for the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      ext_clk_out <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      ext_clk_out <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
    end
  endtask : pulses
endmodule : cct_pin_model

// [dv/tb_cct_timer.sv]
// Self-checking bench for the two-channel capture/compare timer
`timescale 1ns/1ps
module tb_cct_timer;
  import cct_pkg::*;
  logic         ref_clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         ce_in = 1'b1;
  cct_bus_req_t bus_in = '0;
  logic [7:0]   rdata_out;
  logic         ext_clk_pin_in;
  logic [1:0]   chan_pin_in;
  logic [1:0]   chan_pin_out;
  logic [1:0]   chan_pin_oe_n_out;
  logic [1:0]   chan_irq_out;
  logic         wrap_irq_out;
  int           n_errors = 0;
  int           checks_done = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  cct_timer i_cct_timer (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .ext_clk_pin_in(ext_clk_pin_in), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe_n_out(chan_pin_oe_n_out),
    .wrap_irq_out(wrap_irq_out), .chan_irq_out(chan_irq_out));

  cct_pin_model i_cct_pin_model (.ref_clk_in(ref_clk_in),
    .drv_in(chan_pin_out), .oe_n_in(chan_pin_oe_n_out),
    .pin_out(chan_pin_in), .ext_clk_out(ext_clk_pin_in));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, exp, input string what);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1;
    check(rdata_out, exp, what);
  endtask : rd

  // High time and period of channel 0, from one rising edge
  task automatic measure(output int hi, output int per);
    int k;
    k = 0;
    hi = 0;
    while (chan_pin_out[0] !== 1'b0 && k < 600) begin
      step(1);
      k++;
    end
    while (chan_pin_out[0] !== 1'b1 && k < 1200) begin
      step(1);
      k++;
    end
    while (chan_pin_out[0] === 1'b1 && k < 1800) begin
      step(1);
      k++;
      hi++;
    end
    per = hi;
    while (chan_pin_out[0] === 1'b0 && k < 2400) begin
      step(1);
      k++;
      per++;
    end
  endtask : measure

  task automatic count_hi(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      step(1);
      if (chan_pin_out[0] === 1'b1) hi++;
    end
  endtask : count_hi

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset;
    rd(OFS_STAT, 8'h00, "status reset");
    rd(OFS_LIM_HI, 8'hff, "limit hi reset");
    rd(OFS_LIM_LO, 8'hff, "limit lo reset");
    rd(OFS_CH_CTRL[0], 8'h00, "ch0 ctrl reset");
    rd(8'h50, 8'h00, "unmapped read");
    check(chan_pin_oe_n_out, 2'h3, "pins released");
    $display("test reset done");
  endtask : t_reset

  task automatic t_wrap;
    int k;
    wr(OFS_STAT, 8'h30);
    wr(OFS_LIM_HI, 8'h00);
    wr(OFS_LIM_LO, 8'h03);
    wr(OFS_STAT, 8'h00);
    // Counting starts the cycle after stop clears, so the first read
    // sees one; reads two cycles apart then step twice mod four
    rd(OFS_CNT_LO, 8'h01, "count lo");
    for (k = 1; k < 5; k++) begin
      rd(OFS_CNT_LO, 8'((2 * k + 1) % 4), "modulo step");
    end
    rd(OFS_CNT_HI, 8'h00, "count hi");
    wr(OFS_STAT, 8'h20);
    rd(OFS_STAT, 8'h20, "wrap flag cleared");
    wr(OFS_STAT, 8'h40);
    step(8);
    check(wrap_irq_out, 1'b1, "wrap request");
    rd(OFS_STAT, 8'hc0, "wrap flag set");
    // Rate select 2 steps every fourth cycle: three steps in 12 cycles
    wr(OFS_STAT, 8'h32);
    wr(OFS_STAT, 8'h02);
    step(11);
    rd(OFS_CNT_LO, 8'h03, "divided rate");
    $display("test wrap done");
  endtask : t_wrap

  task automatic t_pwm;
    int hi;
    int per;
    wr(OFS_STAT, 8'h30);
    wr(OFS_LIM_LO, 8'hff);
    wr(OFS_CH_HI[0], 8'h00);
    wr(OFS_CH_LO[0], 8'h80);
    wr(OFS_CH_CTRL[0], 8'h5a);
    wr(OFS_STAT, 8'h00);
    measure(hi, per);
    check(16'(per), 16'h0100, "pwm period");
    check(16'(hi), 16'h0081, "pulse width");
    check(chan_irq_out[0], 1'b1, "compare request");
    rd(OFS_CH_CTRL[0], 8'hda, "compare flag");
    wr(OFS_CH_CTRL[0], 8'h18);
    step(300);
    count_hi(260, hi);
    check(16'(hi), 16'h0000, "zero duty");
    wr(OFS_CH_CTRL[0], 8'h1c);
    step(300);
    check(chan_pin_out[0], 1'b1, "set on compare");
    // One match falls in any 256 steps, so the pin flips once
    wr(OFS_CH_CTRL[0], 8'h14);
    step(256);
    check(chan_pin_out[0], 1'b0, "toggle on compare");
    wr(OFS_CH_CTRL[0], 8'h1b);
    step(300);
    count_hi(260, hi);
    check(16'(hi), 16'h0104, "full duty");
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_capture;
    wr(OFS_CH_CTRL[0], 8'h00);
    wr(OFS_CH_CTRL[1], 8'h44);
    wr(OFS_STAT, 8'h37);
    wr(OFS_STAT, 8'h07);
    i_cct_pin_model.pulses(5);
    rd(OFS_CNT_LO, 8'h05, "ext clock count");
    i_cct_pin_model.set_pin(1, 1'b1);
    step(10);
    rd(OFS_CH_LO[1], 8'h05, "captured value");
    rd(OFS_CH_CTRL[1], 8'hc4, "capture flag");
    check(chan_irq_out[1], 1'b1, "capture request");
    i_cct_pin_model.pulses(3);
    i_cct_pin_model.set_pin(1, 1'b0);
    step(10);
    rd(OFS_CH_LO[1], 8'h05, "falling edge ignored");
    i_cct_pin_model.set_pin(1, 1'b1);
    step(10);
    rd(OFS_CH_LO[1], 8'h08, "overwrite with flag set");
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    step(2);
    rst_n_in <= 1'b1;
    rd(OFS_CH_LO[1], 8'h08, "value kept over reset");
    rd(OFS_CH_HI[1], 8'h00, "value hi kept");
    $display("test capture done");
  endtask : t_capture

  task automatic t_linked;
    int hi;
    int per;
    wr(OFS_STAT, 8'h30);
    // The mid-run reset put the limit back to all ones
    wr(OFS_LIM_HI, 8'h00);
    wr(OFS_LIM_LO, 8'hff);
    wr(OFS_CH_HI[0], 8'h00);
    wr(OFS_CH_LO[0], 8'h40);
    wr(OFS_CH_CTRL[1], 8'h1a);
    wr(OFS_CH_CTRL[0], 8'h3a);
    wr(OFS_STAT, 8'h00);
    measure(hi, per);
    check(16'(hi), 16'h0041, "ch0 pair first");
    check(chan_pin_oe_n_out[1], 1'b1, "ch1 pin released");
    wr(OFS_CH_HI[1], 8'h00);
    wr(OFS_CH_LO[1], 8'hc0);
    measure(hi, per);
    measure(hi, per);
    check(16'(hi), 16'h00c1, "ch1 pair after wrap");
    wr(OFS_CH_LO[0], 8'h20);
    measure(hi, per);
    measure(hi, per);
    check(16'(hi), 16'h0021, "last written pair");
    check(16'(per), 16'h0100, "linked period");
    $display("test linked done");
  endtask : t_linked

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #200us;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_wrap();
    t_pwm();
    t_capture();
    t_linked();
    finish_test();
  end
endmodule : tb_cct_timer
